// [hw/serial_port_pkg.sv]
// Constants, register map and types for the asynchronous serial port
package serial_port_pkg;
    // Word offsets (byte addresses) on the register bus
    localparam logic [5:0] ADDR_INTCTL = 6'h00;
    localparam logic [5:0] ADDR_FLAGS  = 6'h04;
    localparam logic [5:0] ADDR_ENABLE = 6'h08;
    localparam logic [5:0] ADDR_PRIO   = 6'h0C;
    localparam logic [5:0] ADDR_RXSTAT = 6'h10;
    localparam logic [5:0] ADDR_TXBUF  = 6'h14;
    localparam logic [5:0] ADDR_TXSTAT = 6'h18;
    localparam logic [5:0] ADDR_BAUD   = 6'h1C;
    localparam logic [5:0] ADDR_RXBUF  = 6'h20;
    // Bit positions
    localparam int GIE_BIT    = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT   = 6;
    localparam int RXIRQ_BIT  = 5;
    localparam int TXIRQ_BIT  = 4;
    localparam int PEN_BIT    = 7;
    localparam int RX9_BIT    = 6;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT   = 4;
    localparam int FRAMING_ERROR_BIT   = 2;
    localparam int OVERRUN_ERROR_BIT   = 1;
    localparam int RECEIVED_NINTH_BIT_BIT   = 0;
    localparam int TX9_BIT    = 6;
    localparam int TRANSMIT_ENABLE_BIT   = 5;
    localparam int SYNC_BIT   = 4;
    localparam int HIGH_BAUD_SELECT_BIT   = 2;
    localparam int SHIFTER_EMPTY_STATUS_BIT   = 1;
    localparam int TRANSMIT_NINTH_BIT_BIT   = 0;
    // Reset values
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_TXSTAT = 8'h02;
    // Oversampling ratios
    localparam int OVS_HIGH = 16;
    localparam int OVS_LOW  = 64;
    localparam logic [3:0] RX_MID = 4'h7;
    localparam logic [1:0] SETTLE_CYC = 2'h2;
    // Line state
    typedef struct packed {
        logic tx;
        logic irq;
    } line_out_t;
    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA  = 5'b00100,
        TX_STOP  = 5'b01000,
        TX_LOAD  = 5'b10000
    } tx_state_t;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_t;
endpackage : serial_port_pkg

// [hw/async_serial_port.sv]
// Asynchronous serial transmitter and receiver with Wishbone registers
`timescale 1ns/100ps
module async_serial_port (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [31:0]               wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    output logic                           wb_err_o,
    input  wire logic                      receive_pin,
    output serial_port_pkg::line_out_t     line_o
);
    import serial_port_pkg::*;

    logic [7:0] intctl_r, enable_r, prio_r, baud_divisor_r;
    logic [7:0] transmit_buffer_r, receive_buffer_r;
    logic       port_enable_r, nine_bit_receive_r, continuous_receive_enable_r;
    logic       framing_error_r, overrun_error_r, received_ninth_bit_r;
    logic       nine_bit_transmit_r, transmit_enable_r, sync_select_r;
    logic       high_baud_select_r, transmit_ninth_bit_r;
    logic       txbuf_full_r, tx_flag_r, rx_flag_r;
    logic [1:0] tx_settle_r;
    logic       ack_r, err_r;
    logic [31:0] rdata_r;
    logic       wr_en, rd_en, hit;
    logic       async_on;

    // Bus strobes, low byte lane carries all registers
    assign wr_en = wb_cyc_i & wb_stb_i & ~ack_r & wb_we_i & wb_sel_i[0];
    assign rd_en = wb_cyc_i & wb_stb_i & ~ack_r & ~wb_we_i;
    assign async_on = port_enable_r & ~sync_select_r;

    // Address decode for mapped offsets
    always_comb begin
        if (wb_adr_i[31:6] != '0) begin
            hit = 1'b0;
        end else if (wb_adr_i[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (wb_adr_i[5:0] <= ADDR_RXBUF) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // Shared baud generator: tick at 16x bit rate in high-speed mode, 64x in low-speed mode
    logic [7:0] brg_cnt_r;
    logic [1:0] pre_cnt_r;
    logic       brg_tick, os_tick;
    assign brg_tick = (brg_cnt_r == 8'h00);
    always_ff @(posedge clock) begin
        if (rst || !async_on) begin
            brg_cnt_r <= baud_divisor_r;
        end else if (brg_tick) begin
            brg_cnt_r <= baud_divisor_r;
        end else begin
            brg_cnt_r <= brg_cnt_r - 8'h01;
        end
    end
    // Low-speed mode divides by four more to reach 64x
    always_ff @(posedge clock) begin
        if (rst || !async_on) begin
            pre_cnt_r <= 2'h0;
        end else if (brg_tick) begin
            pre_cnt_r <= pre_cnt_r + 2'h1;
        end
    end
    assign os_tick = brg_tick &
        (high_baud_select_r || pre_cnt_r == 2'h3);

    // Transmitter
    tx_state_t  tx_state_r;
    logic [8:0] tx_shift_r;
    logic [3:0] tx_os_r, tx_bit_r;
    logic       tx_line_r, tx_load;
    assign tx_load = (tx_state_r == TX_LOAD);
    always_ff @(posedge clock) begin
        if (rst || !async_on || !transmit_enable_r) begin
            tx_state_r <= TX_IDLE;
            tx_line_r  <= 1'b1;
            tx_shift_r <= '0;
            tx_os_r    <= 4'h0;
            tx_bit_r   <= 4'h0;
        end else begin
            case (tx_state_r)
                TX_IDLE: begin
                    tx_line_r <= 1'b1;
                    if (txbuf_full_r) begin
                        tx_state_r <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    // One cycle move from buffer to shifter
                    tx_shift_r <= {transmit_ninth_bit_r, transmit_buffer_r};
                    tx_line_r  <= 1'b0;   // Start bit spans full 16 ticks
                    tx_os_r    <= 4'h0;
                    tx_state_r <= TX_START;
                end
                TX_START: begin
                    tx_line_r <= 1'b0;
                    if (os_tick) begin
                        tx_os_r <= tx_os_r + 4'h1;
                        if (tx_os_r == 4'hF) begin
                            tx_state_r <= TX_DATA;
                            tx_bit_r   <= 4'h0;
                            tx_line_r  <= tx_shift_r[0];
                        end
                    end
                end
                TX_DATA: begin
                    tx_line_r <= tx_shift_r[0];
                    if (os_tick) begin
                        tx_os_r <= tx_os_r + 4'h1;
                        if (tx_os_r == 4'hF) begin
                            // LSb first
                            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                            tx_bit_r   <= tx_bit_r + 4'h1;
                            if (tx_bit_r == (nine_bit_transmit_r ?
                                             4'h8 : 4'h7)) begin
                                tx_state_r <= TX_STOP;
                            end
                        end
                    end
                end
                TX_STOP: begin
                    tx_line_r <= 1'b1;
                    if (os_tick) begin
                        tx_os_r <= tx_os_r + 4'h1;
                        if (tx_os_r == 4'hF) begin
                            // Reload at once if a word waits
                            tx_state_r <= txbuf_full_r ? TX_LOAD : TX_IDLE;
                        end
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // Transmit buffer occupancy; a disabled transmitter holds no word
    logic txbuf_wr;
    assign txbuf_wr = wr_en && wb_adr_i[5:0] == ADDR_TXBUF;
    always_ff @(posedge clock) begin
        if (rst || !transmit_enable_r) begin
            txbuf_full_r <= 1'b0;
        end else if (txbuf_wr) begin
            txbuf_full_r <= 1'b1;
        end else if (tx_load) begin
            txbuf_full_r <= 1'b0;
        end
    end
    // Flag shows the emptiness after a two-cycle settle
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_settle_r <= 2'h0;
            tx_flag_r   <= 1'b0;
        end else begin
            if (txbuf_wr) begin
                tx_settle_r <= SETTLE_CYC;
            end else if (tx_settle_r != 2'h0) begin
                tx_settle_r <= tx_settle_r - 2'h1;
            end
            if (txbuf_wr || tx_settle_r > 2'h1) begin
                tx_flag_r <= tx_flag_r;
            end else if (tx_settle_r == 2'h1) begin
                tx_flag_r <= ~txbuf_full_r;
            end else if (tx_load) begin
                tx_flag_r <= 1'b1;
            end else if (transmit_enable_r) begin
                tx_flag_r <= ~txbuf_full_r;
            end
        end
    end

    // Receiver input synchroniser
    logic rx_meta_r, rx_sync_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= receive_pin;
            rx_sync_r <= rx_meta_r;
        end
    end

    // Receiver sampling at 16x bit rate
    rx_state_t  rx_state_r;
    logic [8:0] rx_shift_r;
    logic [3:0] rx_os_r, rx_bit_r;
    logic       rx_done, rx_stop_ok;
    logic       rx_run;
    assign rx_run = async_on & continuous_receive_enable_r & ~overrun_error_r;
    always_ff @(posedge clock) begin
        if (rst || !rx_run) begin
            rx_state_r <= RX_IDLE;
            rx_shift_r <= '0;
            rx_os_r    <= 4'h0;
            rx_bit_r   <= 4'h0;
            rx_done    <= 1'b0;
            rx_stop_ok <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (rx_state_r)
                RX_IDLE: begin
                    rx_os_r <= 4'h0;
                    if (!rx_sync_r) begin
                        rx_state_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (os_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == RX_MID) begin
                            // Glitch rejection on the start bit
                            if (rx_sync_r) begin
                                rx_state_r <= RX_IDLE;
                            end else begin
                                rx_os_r    <= 4'h0;
                                rx_bit_r   <= 4'h0;
                                rx_state_r <= RX_DATA;
                            end
                        end
                    end
                end
                RX_DATA: begin
                    if (os_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == 4'hF) begin
                            // LSb first into the top
                            if (nine_bit_receive_r) begin
                                rx_shift_r <= {rx_sync_r, rx_shift_r[8:1]};
                            end else begin
                                rx_shift_r <= {1'b0, rx_sync_r,
                                               rx_shift_r[7:1]};
                            end
                            rx_bit_r <= rx_bit_r + 4'h1;
                            if (rx_bit_r == (nine_bit_receive_r ?
                                             4'h8 : 4'h7)) begin
                                rx_state_r <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (os_tick) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == 4'hF) begin
                            rx_stop_ok <= rx_sync_r;
                            rx_done    <= 1'b1;
                            rx_state_r <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer, done flag and errors; no parity check
    logic rxbuf_rd;
    assign rxbuf_rd = rd_en && wb_adr_i[5:0] == ADDR_RXBUF;
    always_ff @(posedge clock) begin
        if (rst) begin
            receive_buffer_r     <= RST_ZERO;
            received_ninth_bit_r <= 1'b0;
            rx_flag_r            <= 1'b0;
            framing_error_r      <= 1'b0;
            overrun_error_r      <= 1'b0;
        end else if (rx_done && rx_flag_r && !rxbuf_rd) begin
            overrun_error_r <= 1'b1;
        end else if (rx_done) begin
            // A completion beats a simultaneous read
            receive_buffer_r     <= rx_shift_r[7:0];
            received_ninth_bit_r <= rx_shift_r[8];
            framing_error_r      <= ~rx_stop_ok;
            rx_flag_r            <= 1'b1;
        end else begin
            if (rxbuf_rd) begin
                rx_flag_r <= 1'b0;
            end
            if (!continuous_receive_enable_r) begin
                framing_error_r <= 1'b0;
                overrun_error_r <= 1'b0;
            end
        end
    end

    // Software-written control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            intctl_r            <= RST_ZERO;
            enable_r            <= RST_ZERO;
            prio_r              <= RST_ZERO;
            baud_divisor_r      <= RST_ZERO;
            transmit_buffer_r   <= RST_ZERO;
            port_enable_r       <= 1'b0;
            nine_bit_receive_r  <= 1'b0;
            continuous_receive_enable_r              <= 1'b0;
            nine_bit_transmit_r <= 1'b0;
            transmit_enable_r   <= 1'b0;
            sync_select_r       <= 1'b0;
            high_baud_select_r  <= 1'b0;
            transmit_ninth_bit_r <= 1'b0;
        end else if (wr_en) begin
            if (wb_adr_i[5:0] == ADDR_INTCTL) begin
                intctl_r <= wb_dat_i[7:0] & 8'hC0;
            end else if (wb_adr_i[5:0] == ADDR_ENABLE) begin
                enable_r <= wb_dat_i[7:0] & 8'h30;
            end else if (wb_adr_i[5:0] == ADDR_PRIO) begin
                prio_r <= wb_dat_i[7:0] & 8'h30;
            end else if (wb_adr_i[5:0] == ADDR_RXSTAT) begin
                port_enable_r      <= wb_dat_i[PEN_BIT];
                nine_bit_receive_r <= wb_dat_i[RX9_BIT];
                continuous_receive_enable_r             <= wb_dat_i[CONTINUOUS_RECEIVE_ENABLE_BIT];
            end else if (wb_adr_i[5:0] == ADDR_TXBUF) begin
                transmit_buffer_r <= wb_dat_i[7:0];
            end else if (wb_adr_i[5:0] == ADDR_TXSTAT) begin
                nine_bit_transmit_r  <= wb_dat_i[TX9_BIT];
                transmit_enable_r    <= wb_dat_i[TRANSMIT_ENABLE_BIT];
                sync_select_r        <= wb_dat_i[SYNC_BIT];
                high_baud_select_r   <= wb_dat_i[HIGH_BAUD_SELECT_BIT];
                transmit_ninth_bit_r <= wb_dat_i[TRANSMIT_NINTH_BIT_BIT];
            end else if (wb_adr_i[5:0] == ADDR_BAUD) begin
                baud_divisor_r <= wb_dat_i[7:0];
            end
        end
    end

    // Read mux; unimplemented bits read zero
    logic [7:0] rmux;
    logic       shifter_empty_status;
    assign shifter_empty_status = (tx_state_r == TX_IDLE);
    always_comb begin
        rmux = 8'h00;
        if (wb_adr_i[5:0] == ADDR_INTCTL) begin
            rmux = intctl_r;
        end else if (wb_adr_i[5:0] == ADDR_FLAGS) begin
            rmux[RXIRQ_BIT] = rx_flag_r;
            rmux[TXIRQ_BIT] = tx_flag_r;
        end else if (wb_adr_i[5:0] == ADDR_ENABLE) begin
            rmux = enable_r;
        end else if (wb_adr_i[5:0] == ADDR_PRIO) begin
            rmux = prio_r;
        end else if (wb_adr_i[5:0] == ADDR_RXSTAT) begin
            rmux[PEN_BIT]  = port_enable_r;
            rmux[RX9_BIT]  = nine_bit_receive_r;
            rmux[CONTINUOUS_RECEIVE_ENABLE_BIT] = continuous_receive_enable_r;
            rmux[FRAMING_ERROR_BIT] = framing_error_r;
            rmux[OVERRUN_ERROR_BIT] = overrun_error_r;
            rmux[RECEIVED_NINTH_BIT_BIT] = received_ninth_bit_r;
        end else if (wb_adr_i[5:0] == ADDR_TXBUF) begin
            rmux = transmit_buffer_r;
        end else if (wb_adr_i[5:0] == ADDR_TXSTAT) begin
            rmux[TX9_BIT]  = nine_bit_transmit_r;
            rmux[TRANSMIT_ENABLE_BIT] = transmit_enable_r;
            rmux[SYNC_BIT] = sync_select_r;
            rmux[HIGH_BAUD_SELECT_BIT] = high_baud_select_r;
            rmux[SHIFTER_EMPTY_STATUS_BIT] = shifter_empty_status;
            rmux[TRANSMIT_NINTH_BIT_BIT] = transmit_ninth_bit_r;
        end else if (wb_adr_i[5:0] == ADDR_BAUD) begin
            rmux = baud_divisor_r;
        end else if (wb_adr_i[5:0] == ADDR_RXBUF) begin
            rmux = receive_buffer_r;
        end
    end

    // Bus answer one cycle after the request; unmapped gets err
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r   <= wb_cyc_i & wb_stb_i & ~ack_r & ~err_r & hit;
            err_r   <= wb_cyc_i & wb_stb_i & ~ack_r & ~err_r & ~hit;
            rdata_r <= {24'h000000, rmux};
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdata_r;

    // Line outputs; interrupt needs both global enables
    always_ff @(posedge clock) begin
        if (rst) begin
            line_o <= '{tx: 1'b1, irq: 1'b0};
        end else begin
            line_o.tx  <= tx_line_r;
            line_o.irq <= intctl_r[GIE_BIT] & intctl_r[PERIPHERAL_IRQ_ENABLE_BIT] &
                ((tx_flag_r & enable_r[TXIRQ_BIT]) |
                 (rx_flag_r & enable_r[RXIRQ_BIT]));
        end
    end
endmodule : async_serial_port

// [sim/serial_peer.sv]
// Behavioural remote serial peer: frame sender and line decoder
`timescale 1ns/100ps
module serial_peer (
    input  wire logic        clock,
    input  wire logic        tx,
    input  wire logic        nine,
    input  wire logic [15:0] bit_clocks,
    output logic             rx,
    output logic [9:0]       got,
    output logic             got_stb
);
    // Line idles high through its pull-up
    initial rx = 1'b1;

    // Send start, data LSb first, then the given stop level
    task automatic send(input logic [8:0] w, input logic stop);
        int n;
        logic b;
        n = nine ? 10 : 9;
        for (int i = 0; i <= n; i++) begin
            b = (i == 0) ? 1'b0 : (i == n) ? stop : w[i-1];
            @(posedge clock) rx <= b;
            repeat (bit_clocks - 1) @(posedge clock);
        end
        @(posedge clock) rx <= 1'b1;
        repeat (bit_clocks * 2) @(posedge clock);
    endtask : send

    // Decode frames on the device line at mid-bit, stop kept in bit 9
    initial begin
        got_stb = 1'b0;
        forever begin
            @(negedge tx);
            got = 10'h0;
            repeat (bit_clocks / 2) @(posedge clock);
            for (int i = 0; i < 10; i++) begin
                if (i < 8 || (i == 8 && nine) || i == 9) begin
                    repeat (bit_clocks) @(posedge clock);
                    got[i] = tx;
                end
            end
            got_stb <= 1'b1;
            @(posedge clock);
            got_stb <= 1'b0;
        end
    end
endmodule : serial_peer

// [sim/async_serial_port_asserts.sv]
// Checker of bus answers and line behaviour at the serial port's ports
`timescale 1ns/100ps
module async_serial_port_asserts (
    input wire logic                       clock,
    input wire logic                       rst,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [31:0]                wb_adr_i,
    input wire logic [31:0]                wb_dat_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [31:0]                wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire logic                       wb_err_o,
    input wire logic                       receive_pin,
    input wire serial_port_pkg::line_out_t line_o
);
    import serial_port_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // New request and acknowledged read
    logic req;
    logic rd_ok;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign rd_ok = wb_ack_o && !wb_we_i;

    // Bus answers
    ack_next_a: assert property (req |=> wb_ack_o || wb_err_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    resp_excl_a: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    unmapped_err_a: assert property (req && wb_adr_i == 32'h24
        |=> wb_err_o && !wb_ack_o) else $error("unmapped not refused");
    // Unused read bits
    high_zero_a: assert property (rd_ok |->
        wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    flags_zero_a: assert property (rd_ok &&
        wb_adr_i == {26'h0, ADDR_FLAGS}
        |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[3:0] == 4'h0)
        else $error("unused flag bits set");
    txstat_zero_a: assert property (rd_ok &&
        wb_adr_i == {26'h0, ADDR_TXSTAT}
        |-> !wb_dat_o[7] && !wb_dat_o[3]) else $error("unused status bits set");
    // Line and interrupt
    reset_idle_a: assert property ($fell(rst) |-> line_o.tx && !line_o.irq)
        else $error("line not idle after reset");
    start_bit_a: assert property ($fell(line_o.tx) |->
        !line_o.tx [*8]) else $error("start bit too short");
    irq_gate_a: assert property (wb_ack_o && wb_we_i &&
        wb_sel_i[0] &&
        wb_adr_i == {26'h0, ADDR_INTCTL} && !(wb_dat_i[GIE_BIT] &&
        wb_dat_i[PERIPHERAL_IRQ_ENABLE_BIT]) |-> ##2 !line_o.irq) else $error("irq not gated");
    cover property (rd_ok && wb_adr_i == {27'h0, ADDR_RXBUF});
    cover property (wb_err_o);
    cover property ($rose(line_o.irq));
endmodule : async_serial_port_asserts

bind async_serial_port async_serial_port_asserts chk (.clock(clock),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .receive_pin(receive_pin), .line_o(line_o));

// [sim/tb_top.sv]
// Testbench: register bus, transmit and receive paths of the serial port
`timescale 1ns/100ps
module tb_top;
    import serial_port_pkg::*;
    logic        clock, rst, cyc, stb, we, ack, err, pin, nine, got_stb;
    logic [31:0] adr, wdat, rdat;
    logic [3:0]  sel;
    logic [15:0] bitc;
    logic [9:0]  got;
    logic [7:0]  b, c;
    line_out_t   lo;
    int          err_total, checks_done, cyc_n;
    logic [32:0] rq[$];
    logic [9:0]  fq[$];
    logic [7:0]  rstv[9] = '{0, 0, 0, 0, 0, 0, RST_TXSTAT, 0, 0};

    async_serial_port dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .receive_pin(pin), .line_o(lo));
    serial_peer peer (.clock(clock), .tx(lo.tx), .nine(nine),
        .bit_clocks(bitc), .rx(pin), .got(got), .got_stb(got_stb));

    // Clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // One classic cycle, held until answered; reads note what they expect
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [32:0] e);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        wdat <= {24'h0, e[7:0]};
        if (!w) rq.push_back(e);
        do @(posedge clock); while (!(ack || err));
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {25'h0, d});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, {25'h0, e});
    endtask : rd

    // Wait for all frames, then one more bit so the stop bit ends
    task automatic drain;
        while (fq.size() != 0) @(posedge clock);
        repeat (bitc) @(posedge clock);
    endtask : drain

    // Result watcher: read answers, decoded frames, hang limit
    always @(posedge clock) begin
        if ((ack || err) && !we && rq.size() != 0)
            check({err, err ? 32'h0 : rdat}, rq.pop_front());
        if (got_stb && fq.size() != 0)
            check({23'h0, got}, {23'h0, fq.pop_front()});
        cyc_n++;
        if (cyc_n > 20000) begin
            err_total++;
            report_and_stop;
        end
    end

    initial begin
        {rst, cyc, stb, we, nine, adr, wdat, sel} = {1'b1, 72'h0};
        bitc = 16'd16;
        void'($urandom(55));
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        sel <= 4'hF;
        foreach (rstv[i]) rd(8'(i * 4), rstv[i]);
        bus(1'b0, 8'h24, {1'b1, 32'h0});
        b = 8'($urandom);
        foreach (rstv[i]) wr(8'(i * 4), 8'hFF);
        rd(8'h00, 8'hC0);
        rd(8'h04, 8'h10);
        rd(8'h08, 8'h30);
        rd(8'h0C, 8'h30);
        wr(8'h1C, b);
        rd(8'h1C, b);
        wr(8'h00, 8'h00);
        wr(8'h08, 8'h00);
        wr(8'h18, 8'h00);
        $display("test registers done");
        // Back-to-back words at x16, divisor 0, then a nine-bit word, then a word at x64, divisor 1
        wr(8'h1C, 8'h00);
        wr(8'h10, 8'h80);
        wr(8'h18, 8'h24);
        rd(8'h04, 8'h10);
        {b, c} = 16'($urandom);
        fq.push_back({2'b10, b});
        fq.push_back({2'b10, c});
        wr(8'h14, b);
        repeat (8) @(posedge clock);
        rd(8'h18, 8'h24);
        wr(8'h14, c);
        repeat (2) @(posedge clock);
        rd(8'h04, 8'h00);
        drain();
        rd(8'h18, 8'h26);
        rd(8'h04, 8'h10);
        nine <= 1'b1;
        wr(8'h18, 8'h65);
        fq.push_back({2'b11, b});
        wr(8'h14, b);
        drain();
        nine <= 1'b0;
        wr(8'h1C, 8'h01);
        wr(8'h18, 8'h20);
        bitc <= 16'd128;
        fq.push_back({2'b10, c});
        wr(8'h14, c);
        drain();
        wr(8'h1C, 8'h00);
        wr(8'h18, 8'h24);
        bitc <= 16'd16;
        $display("test transmit done");
        // Receive, interrupt gating, ninth bit, framing, overrun
        wr(8'h08, 8'h20);
        wr(8'h00, 8'h80);
        wr(8'h10, 8'h90);
        peer.send({1'b0, b}, 1'b1);
        check({32'h0, lo.irq}, 33'h0);
        wr(8'h00, 8'hC0);
        repeat (3) @(posedge clock);
        check({32'h0, lo.irq}, 33'h1);
        rd(8'h04, 8'h30);
        rd(8'h10, 8'h90);
        rd(8'h20, b);
        rd(8'h04, 8'h10);
        nine <= 1'b1;
        wr(8'h10, 8'hD0);
        peer.send({1'b1, c}, 1'b1);
        rd(8'h10, 8'hD1);
        rd(8'h20, c);
        nine <= 1'b0;
        wr(8'h10, 8'h90);
        peer.send({1'b0, b}, 1'b0);
        rd(8'h10, 8'h94);
        rd(8'h20, b);
        peer.send({1'b0, c}, 1'b1);
        peer.send({1'b0, b}, 1'b1);
        rd(8'h10, 8'h92);
        rd(8'h20, c);
        wr(8'h10, 8'h80);
        rd(8'h10, 8'h80);
        $display("test receive done");
        report_and_stop;
    end
endmodule : tb_top
